//--- efc_pkg.sv
/*
 * Package of the FIFO controller: register map, fields,
 * reset values, carriers and the rounding helper.
 * Assumes it is compiled before the design modules.
 */
// Notes on behaviour
// RULE1: With receive enable set, frames from the filter engine are written into storage; the beat carrying the start strobe is not written.
// RULE2: With receive enable clear, arriving frames are aborted and nothing is written.
// RULE3: Once enabled, storing starts with the next whole frame, not one in progress.
// RULE4: Clearing receive enable mid-frame lets the frame finish before disabling.
// RULE5: Disabled flag (bit 20) sets when disabling completes; write one clears.
// RULE6: Frames aborted because receive is disabled never raise the dropped-frame flag.
// RULE7: Writing one to receive bit 30 resets receive logic, flushes transmit-side pipeline.
// RULE8: Software disables a FIFO before writing its reset bit, both directions.
// RULE9: With store-bad-frames bit 25 set, errored frames are kept, not discarded.
// RULE10: Errored means receive, FCS, runt, alignment, jabber, undersize or oversize error.
// RULE11: Each FIFO keeps a 16-bit byte count; frames add length rounded to words.
// RULE12: Command and checksum word bytes stored with a frame are counted too.
// RULE13: With transmit enable bit 31 set, stored frames may pass to the MAC.
// RULE14: Clearing transmit enable mid-frame lets it finish, then sets the disabled flag.
// RULE15: In half duplex a retry after disabling discards the frame; no more retries.
// RULE16: Writing one to transmit bit 30 resets transmit logic, flushes receive-side pipeline.
// RULE17: Overflow bit 24 and dropped bit 23 set on events, cleared by writing one.
// RULE18: Counts drop by a frame's space when read out; a FIFO reset zeroes them.

package efc_pkg;

    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam int          USED_W        = 16;
    localparam int          EXTRA_W       = 8;
    localparam int          IRQ_W         = 4;

    localparam logic [11:0] OFS_RX_CTL    = 12'h0c0;
    localparam logic [11:0] OFS_TX_CTL    = 12'h0c4;
    localparam logic [11:0] OFS_IRQ_STS   = 12'h100;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h104;

    localparam int          BIT_ENABLE    = 31;
    localparam int          BIT_RESET     = 30;
    localparam int          BIT_STORE_BAD = 25;
    localparam int          BIT_OVERFLOW  = 24;
    localparam int          BIT_DROPPED   = 23;
    localparam int          BIT_DISABLED  = 20;

    localparam int          IRQ_RX_DIS    = 0;
    localparam int          IRQ_RX_OVF    = 1;
    localparam int          IRQ_RX_DROP   = 2;
    localparam int          IRQ_TX_DIS    = 3;

    localparam logic [16:0] WORD_ROUND    = 17'h00003;
    localparam logic [16:0] WORD_MASK     = 17'h1fffc;
    localparam logic [15:0] USED_RESET    = 16'h0000;
    localparam logic [3:0]  MASK_RESET    = 4'h0;
    localparam int          RX_FIFO_BYTES = 12288;
    localparam int          TX_FIFO_BYTES = 12288;

    typedef struct packed {
        logic rx_error;
        logic fcs_error;
        logic runt;
        logic align_error;
        logic jabber;
        logic undersize;
        logic oversize;
    } efc_err_t;

    typedef struct packed {
        logic [USED_W-1:0]  len;
        logic [EXTRA_W-1:0] extra;
    } efc_size_t;

    typedef struct packed {
        efc_size_t size;
        efc_err_t  err;
    } efc_rx_end_t;

    // Space a frame takes: payload rounded up to a whole word, plus its command words.
    function automatic logic [16:0] efc_occupied(input efc_size_t s);
        logic [16:0] rounded;
        rounded = ({1'b0, s.len} + WORD_ROUND) & WORD_MASK;
        return rounded + {9'h000, s.extra};
    endfunction : efc_occupied

endpackage : efc_pkg

//--- efc_used_counter.sv
/*
 * Byte count of one FIFO: adds a frame's space on entry, removes it on exit.
 * Assumes callers never remove more than was added; a clear overrides both.
 */
`timescale 1ns/1ps
`default_nettype none

module efc_used_counter #(
    parameter int W = 16
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_clr,
    input  wire logic         i_add,
    input  wire logic [W:0]   i_add_bytes,
    input  wire logic         i_sub,
    input  wire logic [W-1:0] i_sub_bytes,
    output logic      [W-1:0] o_used
);

    logic [W:0] next_used;

    always_comb begin
        next_used = {1'b0, o_used};
        if (i_add) begin
            next_used = next_used + i_add_bytes; // [RULE11] [RULE12]
        end
        if (i_sub) begin
            next_used = next_used - {1'b0, i_sub_bytes}; // [RULE18]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_used <= '0;
        end else if (i_clr) begin
            o_used <= '0; // [RULE18]
        end else begin
            o_used <= next_used[W-1:0];
        end
    end

endmodule : efc_used_counter

`default_nettype wire

//--- efc_sticky_flags.sv
/*
 * Vector of sticky flags, set by hardware events and cleared by writing one.
 * Assumes set and clear pulses come from the same clock; a set beats a clear.
 */
`timescale 1ns/1ps
`default_nettype none

module efc_sticky_flags #(
    parameter int W = 4
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_set,
    input  wire logic [W-1:0] i_clr,
    output logic      [W-1:0] o_flags
);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flags <= '0;
        end else begin
            // The set term is ORed last so an event in the clearing cycle is not lost.
            o_flags <= (o_flags & ~i_clr) | i_set; // [RULE5] [RULE17]
        end
    end

endmodule : efc_sticky_flags

`default_nettype wire

//--- efc_fifo_controller.sv
/*
 * Enable, disable, reset and occupancy control of the receive and transmit FIFOs,
 * with control, interrupt status and mask registers and one IRQ line.
 * Assumes the filter engine, MAC and USB pipelines run on i_ref_clk, that a frame's
 * start and end strobes never fall in the same cycle, and a plain register port.
 */
`timescale 1ns/1ps
`default_nettype none

module efc_fifo_controller #(
    parameter int RX_CAPACITY = efc_pkg::RX_FIFO_BYTES,
    parameter int TX_CAPACITY = efc_pkg::TX_FIFO_BYTES
) (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_nrst,
    input  wire logic [efc_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [efc_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [efc_pkg::DATA_W-1:0]   o_rdata,
    input  wire logic                         i_rx_sof,
    input  wire logic                         i_rx_valid,
    input  wire logic                         i_rx_eof,
    input  wire efc_pkg::efc_rx_end_t         i_rx_end,
    output logic                              o_rx_write,
    output logic                              o_rx_commit,
    output logic                              o_rx_discard,
    output logic                              o_rx_abort,
    input  wire logic                         i_rx_read_done,
    input  wire logic [efc_pkg::USED_W-1:0]   i_rx_read_bytes,
    output logic                              o_utx_flush,
    input  wire logic                         i_tx_stored,
    input  wire efc_pkg::efc_size_t           i_tx_stored_size,
    output logic                              o_tx_allow,
    input  wire logic                         i_tx_mac_start,
    input  wire logic [efc_pkg::USED_W-1:0]   i_tx_mac_bytes,
    input  wire logic                         i_tx_mac_done,
    input  wire logic                         i_tx_mac_retry,
    input  wire logic                         i_half_duplex,
    output logic                              o_tx_discard,
    output logic                              o_urx_flush,
    output logic                              o_irq
);

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_STORE,
        RX_SKIP
    } efc_rx_state_t;

    typedef enum logic [0:0] {
        TX_IDLE,
        TX_SEND
    } efc_tx_state_t;

    localparam logic [16:0] RX_CAP = 17'(RX_CAPACITY);
    localparam logic [16:0] TX_CAP = 17'(TX_CAPACITY);

    efc_rx_state_t              rx_state;
    efc_tx_state_t              tx_state;
    logic                       rx_enable;
    logic                       tx_enable;
    logic                       store_bad;
    logic                       rx_reset;
    logic                       tx_reset;
    logic                       rx_dis_pend;
    logic                       tx_dis_pend;
    logic [efc_pkg::USED_W-1:0] tx_cur_bytes;
    logic [efc_pkg::IRQ_W-1:0]  irq_mask;
    logic [efc_pkg::IRQ_W-1:0]  irq_status;
    logic [2:0]                 rx_flags;
    logic                       tx_dis_flag;
    logic [efc_pkg::USED_W-1:0] rx_used;
    logic [efc_pkg::USED_W-1:0] tx_used;

    logic                       wr_rx;
    logic                       wr_tx;
    logic                       wr_sts;
    logic                       wr_mask;
    logic                       rx_errored;
    logic [16:0]                rx_occ;
    logic                       rx_fits;
    logic                       rx_end_store;
    logic                       rx_keep;
    logic                       rx_bad_drop;
    logic                       rx_ovf_drop;
    logic                       rx_dis_set;
    logic                       tx_leave_done;
    logic                       tx_leave_retry;
    logic                       tx_dis_set;
    logic [2:0]                 rx_flag_set;
    logic [2:0]                 rx_flag_clr;
    logic [efc_pkg::IRQ_W-1:0]  irq_set;
    logic [efc_pkg::IRQ_W-1:0]  irq_clr;
    logic [efc_pkg::DATA_W-1:0] rx_ctl_view;
    logic [efc_pkg::DATA_W-1:0] tx_ctl_view;
    logic [efc_pkg::DATA_W-1:0] next_rdata;

    // Register port decode.
    assign wr_rx   = i_wr && (i_addr == efc_pkg::OFS_RX_CTL);
    assign wr_tx   = i_wr && (i_addr == efc_pkg::OFS_TX_CTL);
    assign wr_sts  = i_wr && (i_addr == efc_pkg::OFS_IRQ_STS);
    assign wr_mask = i_wr && (i_addr == efc_pkg::OFS_IRQ_MASK);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_enable <= 1'b0;
            store_bad <= 1'b0;
        end else if (wr_rx) begin
            rx_enable <= i_wdata[efc_pkg::BIT_ENABLE];
            store_bad <= i_wdata[efc_pkg::BIT_STORE_BAD];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_enable <= 1'b0;
        end else if (wr_tx) begin
            tx_enable <= i_wdata[efc_pkg::BIT_ENABLE];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_mask <= efc_pkg::MASK_RESET;
        end else if (wr_mask) begin
            irq_mask <= i_wdata[efc_pkg::IRQ_W-1:0];
        end
    end

    // Reset bits self-clear: a write of one gives one registered pulse.
    // A reset of an enabled FIFO is not refused; software must
    // disable first or a frame in flight is cut silently.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_reset <= 1'b0;
            tx_reset <= 1'b0;
        end else begin
            rx_reset <= wr_rx && i_wdata[efc_pkg::BIT_RESET]; // [RULE7] [RULE8]
            tx_reset <= wr_tx && i_wdata[efc_pkg::BIT_RESET]; // [RULE16] [RULE8]
        end
    end

    assign o_utx_flush = rx_reset; // [RULE7]
    assign o_urx_flush = tx_reset; // [RULE16]

    // Receive frame evaluation at the end strobe.
    assign rx_errored   = |i_rx_end.err; // [RULE10]
    assign rx_occ       = efc_pkg::efc_occupied(i_rx_end.size); // [RULE11] [RULE12]
    assign rx_fits      = rx_occ <= (RX_CAP - {1'b0, rx_used});
    assign rx_end_store = (rx_state == RX_STORE) && i_rx_eof;
    assign rx_bad_drop  = rx_end_store && rx_errored && !store_bad; // [RULE9]
    assign rx_ovf_drop  = rx_end_store && !rx_bad_drop && !rx_fits;
    assign rx_keep      = rx_end_store && !rx_bad_drop && rx_fits;

    // Beats reach storage only while a frame is stored.
    assign o_rx_write = i_rx_valid && (rx_state == RX_STORE); // [RULE1] [RULE2]

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_state <= RX_IDLE;
        end else if (rx_reset) begin
            rx_state <= RX_IDLE;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    if (i_rx_sof && rx_enable) begin
                        rx_state <= RX_STORE; // [RULE1]
                    end else if (i_rx_sof) begin
                        rx_state <= RX_SKIP; // [RULE2]
                    end
                end
                RX_STORE: begin
                    // Enable is ignored here, so a stored frame completes.
                    if (i_rx_eof) begin
                        rx_state <= RX_IDLE; // [RULE4]
                    end
                end
                RX_SKIP: begin
                    // A frame begun while disabled is skipped to its end.
                    if (i_rx_eof) begin
                        rx_state <= RX_IDLE; // [RULE3]
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_commit  <= 1'b0;
            o_rx_discard <= 1'b0;
            o_rx_abort   <= 1'b0;
        end else begin
            o_rx_commit  <= rx_keep && !rx_reset;
            o_rx_discard <= (rx_bad_drop || rx_ovf_drop) && !rx_reset;
            o_rx_abort   <= (rx_state == RX_SKIP) && i_rx_eof && !rx_reset; // [RULE2]
        end
    end

    // Disabling completes once no frame is being stored.
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_dis_pend <= 1'b0;
        end else if (wr_rx && rx_enable && !i_wdata[efc_pkg::BIT_ENABLE]) begin
            rx_dis_pend <= 1'b1; // [RULE5]
        end else if (rx_dis_set || rx_enable) begin
            rx_dis_pend <= 1'b0;
        end
    end

    assign rx_dis_set = rx_dis_pend && !rx_enable && (rx_state != RX_STORE); // [RULE4] [RULE5]

    // Aborted frames raise no flag; only errored or overflowing stores do.
    assign rx_flag_set = {rx_ovf_drop, rx_bad_drop || rx_ovf_drop, rx_dis_set}; // [RULE6] [RULE17]
    assign rx_flag_clr = wr_rx ? {i_wdata[efc_pkg::BIT_OVERFLOW],
                                  i_wdata[efc_pkg::BIT_DROPPED],
                                  i_wdata[efc_pkg::BIT_DISABLED]} : 3'b000;

    efc_sticky_flags #(
        .W (3)
    ) u_rx_flags (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_set     (rx_flag_set),
        .i_clr     (rx_flag_clr),
        .o_flags   (rx_flags)
    );

    efc_used_counter #(
        .W (efc_pkg::USED_W)
    ) u_rx_used (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_clr       (rx_reset),
        .i_add       (rx_keep),
        .i_add_bytes (rx_occ),
        .i_sub       (i_rx_read_done),
        .i_sub_bytes (i_rx_read_bytes),
        .o_used      (rx_used)
    );

    // Transmit side: frames leave only while enabled and idle.
    assign o_tx_allow     = tx_enable && (tx_state == TX_IDLE) && !tx_reset; // [RULE13]
    assign tx_leave_done  = (tx_state == TX_SEND) && i_tx_mac_done;
    assign tx_leave_retry = (tx_state == TX_SEND) && !i_tx_mac_done && i_tx_mac_retry
                            && i_half_duplex && !tx_enable; // [RULE15]

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_state     <= TX_IDLE;
            tx_cur_bytes <= efc_pkg::USED_RESET;
        end else if (tx_reset) begin
            tx_state     <= TX_IDLE;
            tx_cur_bytes <= efc_pkg::USED_RESET;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (i_tx_mac_start && o_tx_allow) begin
                        tx_state     <= TX_SEND; // [RULE13]
                        tx_cur_bytes <= i_tx_mac_bytes;
                    end
                end
                TX_SEND: begin
                    // A frame on the wire runs to its end even if enable drops, unless a half-duplex retry with enable clear discards it.
                    if (tx_leave_done || tx_leave_retry) begin
                        tx_state <= TX_IDLE; // [RULE14] [RULE15]
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tx_discard <= 1'b0;
        end else begin
            o_tx_discard <= tx_leave_retry && !tx_reset; // [RULE15]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_dis_pend <= 1'b0;
        end else if (wr_tx && tx_enable && !i_wdata[efc_pkg::BIT_ENABLE]) begin
            tx_dis_pend <= 1'b1; // [RULE5]
        end else if (tx_dis_set || tx_enable) begin
            tx_dis_pend <= 1'b0;
        end
    end

    assign tx_dis_set = tx_dis_pend && !tx_enable && (tx_state == TX_IDLE); // [RULE14] [RULE5]

    efc_sticky_flags #(
        .W (1)
    ) u_tx_flags (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_set     (tx_dis_set),
        .i_clr     (wr_tx && i_wdata[efc_pkg::BIT_DISABLED]),
        .o_flags   (tx_dis_flag)
    );

    efc_used_counter #(
        .W (efc_pkg::USED_W)
    ) u_tx_used (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_clr       (tx_reset),
        .i_add       (i_tx_stored),
        .i_add_bytes (efc_pkg::efc_occupied(i_tx_stored_size)),
        .i_sub       (tx_leave_done || tx_leave_retry),
        .i_sub_bytes (tx_cur_bytes),
        .o_used      (tx_used)
    );

    // Interrupt status mirrors the four events; write one to clear.
    assign irq_set = {tx_dis_set, rx_bad_drop || rx_ovf_drop, rx_ovf_drop, rx_dis_set};
    assign irq_clr = wr_sts ? i_wdata[efc_pkg::IRQ_W-1:0] : '0;

    efc_sticky_flags #(
        .W (efc_pkg::IRQ_W)
    ) u_irq_status (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_set     (irq_set),
        .i_clr     (irq_clr),
        .o_flags   (irq_status)
    );

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // Read views; reserved bits and the self-clearing reset bits read as zero.
    always_comb begin
        rx_ctl_view                           = '0;
        rx_ctl_view[efc_pkg::BIT_ENABLE]      = rx_enable;
        rx_ctl_view[efc_pkg::BIT_STORE_BAD]   = store_bad;
        rx_ctl_view[efc_pkg::BIT_OVERFLOW]    = rx_flags[2];
        rx_ctl_view[efc_pkg::BIT_DROPPED]     = rx_flags[1];
        rx_ctl_view[efc_pkg::BIT_DISABLED]    = rx_flags[0];
        rx_ctl_view[efc_pkg::USED_W-1:0]      = rx_used; // [RULE11]
        tx_ctl_view                           = '0;
        tx_ctl_view[efc_pkg::BIT_ENABLE]      = tx_enable;
        tx_ctl_view[efc_pkg::BIT_DISABLED]    = tx_dis_flag;
        tx_ctl_view[efc_pkg::USED_W-1:0]      = tx_used; // [RULE11]
    end

    always_comb begin
        next_rdata = '0;
        if (i_rd) begin
            case (i_addr)
                efc_pkg::OFS_RX_CTL: begin
                    next_rdata = rx_ctl_view;
                end
                efc_pkg::OFS_TX_CTL: begin
                    next_rdata = tx_ctl_view;
                end
                efc_pkg::OFS_IRQ_STS: begin
                    next_rdata[efc_pkg::IRQ_W-1:0] = irq_status;
                end
                efc_pkg::OFS_IRQ_MASK: begin
                    next_rdata[efc_pkg::IRQ_W-1:0] = irq_mask;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= next_rdata;
        end
    end

endmodule : efc_fifo_controller

`default_nettype wire

//--- efc_ctl_chk.sv
/* Port checker of the FIFO controller.
   Assumes a bind to the design; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module efc_ctl_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        i_rx_valid,
    input wire logic        i_rx_eof,
    input wire logic        o_rx_write,
    input wire logic        o_rx_commit,
    input wire logic        o_rx_discard,
    input wire logic        o_rx_abort,
    input wire logic        o_tx_allow,
    input wire logic        i_tx_mac_start,
    input wire logic        i_tx_mac_retry,
    input wire logic        i_half_duplex,
    input wire logic        o_tx_discard,
    input wire logic        o_utx_flush,
    input wire logic        o_urx_flush
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    a_write_gate: assert property (o_rx_write |-> i_rx_valid) else $error("write");
    a_abort_eof: assert property (o_rx_abort |-> $past(i_rx_eof) && !o_rx_commit) else $error("abort");
    a_commit_eof: assert property (o_rx_commit |-> $past(i_rx_eof) && !o_rx_discard) else $error("commit");
    a_allow_drop: assert property (o_tx_allow && i_tx_mac_start |=> !o_tx_allow) else $error("allow");
    a_retry_drop: assert property (o_tx_discard |-> $past(i_tx_mac_retry && i_half_duplex)) else $error("retry");
    a_utx_flush: assert property (o_utx_flush |-> $past(i_wr && i_wdata[30] && i_addr == 12'h0c0)) else $error("utx");
    a_urx_flush: assert property (o_urx_flush |-> $past(i_wr && i_wdata[30] && i_addr == 12'h0c4)) else $error("urx");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata");
endmodule : efc_ctl_chk
`default_nettype wire

//--- efc_far_model.sv
/* Filter engine model: three-beat frames with one checksum word.
   Assumes i_go pulses once while length and errors hold. */
`timescale 1ns/1ps
`default_nettype none
module efc_far_model (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_go,
    input  wire logic [15:0]          i_len,
    input  wire logic [6:0]           i_err,
    output logic                      o_sof,
    output logic                      o_valid,
    output logic                      o_eof,
    output var efc_pkg::efc_rx_end_t  o_end
);
    logic [1:0] n;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            n <= 2'h0;
        end else begin
            n <= i_go ? 2'h3 : n - {1'b0, n != 2'h0};
        end
    end
    assign o_sof = n == 2'h3;
    assign o_valid = n != 2'h0;
    assign o_eof = n == 2'h1;
    // Off the end beat the record is scrambled.
    assign o_end = o_eof ? {i_len, 8'h04, i_err} : ~{i_len, 8'h04, i_err};
endmodule : efc_far_model
`default_nettype wire

//--- efc_fifo_controller_bench.sv
/* Bench of the FIFO controller: register tasks and frame sequences.
   Assumes package, design, model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module efc_fifo_controller_bench;
    logic                 i_ref_clk, i_nrst, i_wr, i_rd, i_rx_read_done, i_tx_stored, go;
    logic                 i_tx_mac_start, i_tx_mac_done, i_tx_mac_retry, i_half_duplex;
    logic                 i_rx_sof, i_rx_valid, i_rx_eof, o_rx_write, o_rx_commit, o_rx_discard;
    logic                 o_rx_abort, o_utx_flush, o_tx_allow, o_tx_discard, o_urx_flush, o_irq;
    logic [11:0]          i_addr;
    logic [31:0]          i_wdata, o_rdata;
    logic [15:0]          i_rx_read_bytes, i_tx_mac_bytes, len;
    logic [6:0]           err;
    logic [5:0]           evk;
    efc_pkg::efc_rx_end_t i_rx_end;
    efc_pkg::efc_size_t   i_tx_stored_size;
    int                   n_fail = 0;
    int                   num_checks = 0;
    efc_fifo_controller #(.RX_CAPACITY(64), .TX_CAPACITY(64)) i_dut (.*);
    efc_far_model i_far (.i_ref_clk, .i_nrst, .i_go(go), .i_len(len), .i_err(err),
        .o_sof(i_rx_sof), .o_valid(i_rx_valid), .o_eof(i_rx_eof), .o_end(i_rx_end));
    assign {go, i_rx_read_done, i_tx_stored, i_tx_mac_start, i_tx_mac_done, i_tx_mac_retry} = evk;
    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        // Read data is registered at the strobe edge, so look once it has settled.
        @(negedge i_ref_clk);
        chk(o_rdata, exp);
        @(posedge i_ref_clk);
    endtask : rd
    // One-cycle events: go, read done, stored, start, done, retry.
    task automatic ev(input logic [5:0] k);
        evk <= k;
        @(posedge i_ref_clk);
        evk <= 6'h0;
        @(posedge i_ref_clk);
    endtask : ev
    task automatic frame(input logic [15:0] l, input logic [6:0] e);
        len <= l;
        err <= e;
        ev(6'h20);
        repeat (5) @(posedge i_ref_clk);
    endtask : frame
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (3000) @(posedge i_ref_clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {i_nrst, i_wr, i_rd, i_half_duplex, evk, i_tx_stored_size} = '0;
        {i_addr, i_wdata, i_rx_read_bytes, i_tx_mac_bytes, len, err} = '0;
        repeat (16) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(12'h0c0, 32'h0);
        rd(12'h0f0, 32'h0);
        wr(12'h104, 32'hf);
        wr(12'h0c0, 32'h8000_0000);
        frame(16'd5, 7'h00);
        rd(12'h0c0, 32'h8000_000c);
        for (int i = 0; i < 7; i++) begin
            frame(16'd5, 7'h01 << i);
            rd(12'h0c0, 32'h8080_000c);
        end
        wr(12'h0c0, 32'h8280_0000);
        frame(16'd7, 7'h40);
        frame(16'd60, 7'h00);
        rd(12'h0c0, 32'h8380_0018);
        len <= 16'd5;
        ev(6'h20);
        wr(12'h0c0, 32'h0180_0000);
        rd(12'h0c0, 32'h0010_0024);
        chk(o_irq, 32'h1);
        wr(12'h104, 32'h0);
        chk(o_irq, 32'h0);
        wr(12'h104, 32'hf);
        wr(12'h100, 32'hf);
        chk(o_irq, 32'h0);
        frame(16'd5, 7'h00);
        rd(12'h0c0, 32'h0010_0024);
        ev(6'h20);
        wr(12'h0c0, 32'h8000_0000);
        i_rx_read_bytes <= 16'd12;
        ev(6'h10);
        rd(12'h0c0, 32'h8010_0018);
        wr(12'h0c0, 32'h0010_0000);
        wr(12'h0c0, 32'h4000_0000);
        rd(12'h0c0, 32'h0010_0000);
        i_tx_stored_size <= '{16'd6, 8'd4};
        i_tx_mac_bytes <= 16'd12;
        ev(6'h08);
        rd(12'h0c4, 32'h0000_000c);
        chk(o_tx_allow, 32'h0);
        wr(12'h0c4, 32'h8000_0000);
        chk(o_tx_allow, 32'h1);
        ev(6'h04);
        wr(12'h0c4, 32'h0);
        ev(6'h02);
        rd(12'h0c4, 32'h0010_0000);
        ev(6'h08);
        wr(12'h0c4, 32'h8010_0000);
        ev(6'h04);
        i_half_duplex <= 1'b1;
        wr(12'h0c4, 32'h0);
        ev(6'h01);
        rd(12'h0c4, 32'h0010_0000);
        chk(o_tx_allow, 32'h0);
        ev(6'h08);
        wr(12'h0c4, 32'h4000_0000);
        rd(12'h0c4, 32'h0010_0000);
        tally_and_finish();
    end
endmodule : efc_fifo_controller_bench
bind efc_fifo_controller efc_ctl_chk i_chk (.*);
`default_nettype wire
